//--- host_model.sv
// Purpose: Host side of the three-wire load port
// Assumes: Frames of 24 bits, serial clock period 8 system cycles
// Notes:   Serial clock rests low between frames; data line inverts when idle
module host_model
  import synth_cfg_pkg::*;
(
  // Clock
  input  wire logic sys_clk_i,
  // Load port
  output logic      serial_clk_o,
  output logic      serial_data_o,
  output logic      load_strobe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    serial_clk_o  = 1'b0;
    serial_data_o = 1'b0;
    load_strobe_o = 1'b0;
  end

  task automatic send(input logic [1:0] addr, input logic [WORD_W-1:0] data);
    logic [SH_W-1:0] frame;
    frame = {data, addr};
    for (int i = SH_W - 1; i >= 0; i--) begin
      @(posedge sys_clk_i);
      serial_data_o <= frame[i];
      repeat (2) @(posedge sys_clk_i);
      serial_clk_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      serial_clk_o <= 1'b0;
      @(posedge sys_clk_i);
    end
    repeat (2) @(posedge sys_clk_i);
    load_strobe_o <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    load_strobe_o <= 1'b0;
    // Hold time over: show a changed level so a stale bit is never trusted
    serial_data_o <= ~frame[0];
  endtask
endmodule // host_model

//--- lock_filter.sv
// Purpose: Digital lock filter on reference and feedback events
// Assumes: Events come from the same clock domain
// Notes:   Phase error resolved to whole system clock cycles
module lock_filter
  import synth_cfg_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  lock_if.filt      lk
);
  typedef struct packed {
    logic        open;
    logic [3:0]  err;
    logic [2:0]  good;
    lock_state_e st;
  } flt_s;

  flt_s q_reg;
  flt_s q_next;
  logic good_ev;

  assign lk.locked  = (q_reg.st == LK_HELD);
  assign lk.pump_on = q_reg.open;

  always_comb begin
    q_next  = q_reg;
    good_ev = 1'b0;
    if (!lk.en) begin
      q_next = '{open: 1'b0, err: 4'h0, good: 3'h0, st: LK_HUNT};
    end else begin
      if (!q_reg.open) begin
        if (lk.ref_p && lk.fb_p) begin
          good_ev = 1'b1;
        end else if (lk.ref_p || lk.fb_p) begin
          q_next.open = 1'b1;
          q_next.err  = 4'h1;
        end
      end else if (lk.ref_p || lk.fb_p) begin
        q_next.open = 1'b0;
        good_ev     = (q_reg.err < ENTRY_CYC);
      end else if (q_reg.err != 4'hF) begin
        q_next.err = q_reg.err + 4'h1;
      end
      case (q_reg.st)
        LK_HUNT: begin
          if (q_reg.open && q_reg.err >= ENTRY_CYC) begin
            q_next.good = 3'h0;
          end else if (good_ev) begin
            if (q_reg.good == LOCK_CYCLES - 3'h1) begin
              q_next.st   = LK_HELD;
              q_next.good = 3'h0;
            end else begin
              q_next.good = q_reg.good + 3'h1;
            end
          end
        end
        LK_HELD: begin
          // Exit window EXIT_CYC rounds to the same one cycle as ENTRY_CYC, so it is no wider once held
          if (q_reg.open && q_reg.err >= EXIT_CYC) begin
            q_next.st = LK_HUNT;
          end
        end
        default: q_next.st = LK_HUNT;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_reg <= '{open: 1'b0, err: 4'h0, good: 3'h0, st: LK_HUNT};
    end else begin
      q_reg <= q_next;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_enter;
    $rose(q_reg.st == LK_HELD) |->
      $past(q_reg.good) == LOCK_CYCLES - 3'h1;
  endproperty
  a_enter: assert property (p_enter)
    else $error("lock taken before enough clean cycles");

  property p_drop;
    lk.en && q_reg.st == LK_HELD && q_reg.open && q_reg.err >= EXIT_CYC
      |=> q_reg.st == LK_HUNT;
  endproperty
  a_drop: assert property (p_drop)
    else $error("lock held past wide threshold");

  property p_restart;
    lk.en && q_reg.st == LK_HUNT && q_reg.open && q_reg.err >= ENTRY_CYC
      |=> q_reg.good == 3'h0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("clean count not restarted");

  c_lock: cover property ($rose(q_reg.st == LK_HELD));
  c_unlock: cover property ($fell(q_reg.st == LK_HELD));
endmodule // lock_filter

//--- lock_if.sv
// Purpose: Carries divider events to the lock filter and lock status back from it
// Assumes: Both ends on sys_clk
// Notes:   Pulses are one cycle wide
interface lock_if;
  logic ref_p;
  logic fb_p;
  logic en;
  logic locked;
  logic pump_on;
  modport core (output ref_p, fb_p, en, input locked, pump_on);
  modport filt (input ref_p, fb_p, en, output locked, pump_on);
endinterface

//--- synth_cfg_pkg.sv
// Purpose: Shared constants for the synthesizer configuration block
// Assumes: 20 MHz system clock, 24-bit serial load frame
// Notes:   Word bits are numbered as data bits, address stripped
package synth_cfg_pkg;
  // Word addresses
  localparam logic [1:0]  ADDR_FRAC = 2'h0;
  localparam logic [1:0]  ADDR_PIN  = 2'h1;
  localparam logic [1:0]  ADDR_R    = 2'h2;
  localparam logic [1:0]  ADDR_N    = 2'h3;
  localparam int          SH_W    = 24;
  localparam int          WORD_W  = 22;
  localparam logic [21:0] WORD_RST = 22'h000000;
  // Fraction and lock pin word
  localparam int FRAC_SEL_BIT = 20;
  localparam int LSEL_MSB     = 19;
  localparam int LSEL_LSB     = 17;
  // Output pin and sleep word
  localparam int OUT_A_BIT = 15;
  localparam int OUT_B_BIT = 16;
  localparam int TEST_BIT  = 17;
  localparam int FAST_BIT  = 18;
  localparam int SLEEP_BIT = 19;
  // Reference word
  localparam int R_CNT_MSB  = 14;
  localparam int CP_TOP_BIT = 19;
  // Feedback word
  localparam int NUM_MSB   = 3;
  localparam int SWAL_LSB  = 4;
  localparam int SWAL_MSB  = 8;
  localparam int PROG_LSB  = 9;
  localparam int PROG_MSB  = 18;
  localparam int PRESC_BIT = 19;
  localparam int PWDN_BIT  = 20;
  localparam int CRST_BIT  = 21;
  // Lock pin sources
  localparam logic [2:0] LSEL_ANALOG  = 3'h0;
  localparam logic [2:0] LSEL_DIGITAL = 3'h2;
  localparam logic [2:0] LSEL_NDIV    = 3'h6;
  localparam logic [2:0] LSEL_RDIV    = 3'h7;
  // Moduli
  localparam logic [4:0] FMOD_16 = 5'h10;
  localparam logic [4:0] FMOD_15 = 5'h0F;
  localparam logic [5:0] PMOD_HI = 6'h20;
  localparam logic [5:0] PMOD_LO = 6'h10;
  // Pin sampler lanes
  localparam int PIN_SCLK  = 0;
  localparam int PIN_SDATA = 1;
  localparam int PIN_LOAD  = 2;
  localparam int PIN_OSC   = 3;
  localparam int PIN_FIN   = 4;
  localparam int NPINS     = 5;
  // Lock filter timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int ENTRY_NS      = 15;
  localparam int EXIT_NS       = 30;
  localparam logic [3:0] ENTRY_CYC =
    4'((ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] EXIT_CYC =
    4'((EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0] LOCK_CYCLES = 3'h5;
  typedef enum logic [1:0] {
    LK_HUNT = 2'b01,
    LK_HELD = 2'b10
  } lock_state_e;
endpackage

//--- synth_config.sv
// Purpose: Serial configuration, dividers, lock pin and output pins
// Assumes: All pins asynchronous to sys_clk, slower than 1/4 its rate
// Notes:   Tags below mark the logic that carries each rule
// Operation
// - Feedback count is P times B plus A
// - Fraction is numerator over selected modulus
// - Address 00 loads fraction and lock word
// - Select bit picks modulus 16 or 15
// - Lock pin source decode, four legal codes
// - Locked pin high with narrow low pulses
// - Lock after five clean reference cycles
// - Locked threshold widens, drop beyond it; here EXIT_CYC and ENTRY_CYC both round to one cycle
// - Digital lock output low while unlocked
// - Address 01 loads output and sleep word
// - General mode pins follow two bits
// - Fast bit selects fast-acquire pin mode
// - Fast mode, top current drives pin low
// - Fast mode, top current off floats pin
// - Fast mode ignores bits, second pin floats
// - Test bit overrides both pin modes
// - Data sampled on serial clock rising
// - Strobe rising moves frame into addressed word
// - Sleep immediate or after pump pulse
module synth_config
  import synth_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  // Serial load port
  input  wire logic serial_clk_i,
  input  wire logic serial_data_i,
  input  wire logic load_strobe_i,
  // Divider inputs
  input  wire logic osc_i,
  input  wire logic fin_i,
  // Lock pin
  output logic      lock_indicator_o,
  output logic      lock_indicator_oe_o,
  // General pins
  output logic      general_out_a_pin_o,
  output logic      general_out_a_pin_oe_o,
  output logic      general_out_b_pin_o,
  output logic      general_out_b_pin_oe_o,
  // Status
  output logic      powered_down_o
);
  typedef struct packed {
    logic [NPINS-1:0]  s1;
    logic [NPINS-1:0]  s2;
    logic [NPINS-1:0]  prev;
    logic [SH_W-1:0]   sh;
    logic [WORD_W-1:0] frac_w;
    logic [WORD_W-1:0] pin_w;
    logic [WORD_W-1:0] rw;
    logic [WORD_W-1:0] nw;
    logic [15:0]       n_cnt;
    logic [14:0]       r_cnt;
    logic [3:0]        acc;
    logic              carry;
    logic              ref_p;
    logic              fb_p;
    logic              n_tog;
    logic              r_tog;
    logic              pd;
    logic              lk_o;
    logic              lk_oe;
    logic              a_o;
    logic              a_oe;
    logic              b_o;
    logic              b_oe;
  } st_s;

  localparam st_s ST_RST = '{
    s1: '0, s2: '0, prev: '0, sh: '0,
    frac_w: WORD_RST, pin_w: WORD_RST, rw: WORD_RST, nw: WORD_RST,
    n_cnt: 16'h0000, r_cnt: 15'h0000, acc: 4'h0, carry: 1'b0,
    ref_p: 1'b0, fb_p: 1'b0, n_tog: 1'b0, r_tog: 1'b0, pd: 1'b0,
    lk_o: 1'b0, lk_oe: 1'b0, a_o: 1'b0, a_oe: 1'b0,
    b_o: 1'b0, b_oe: 1'b0};

  st_s q_reg;
  st_s q_next;
  lock_if lk ();

  logic [NPINS-1:0]  pins;
  logic [NPINS-1:0]  rise;
  logic [WORD_W-1:0] frame;
  logic [SH_W-1:0]   sh_shift;
  logic [2:0]        lsel;
  logic [4:0]        fmod;
  logic [5:0]        pmod;
  logic [4:0]        fsum;
  logic [15:0]       n_total;
  logic              halt;
  logic              fast;
  logic              test;

  // Address decode shared by all four word loads
  function automatic logic load_hit(input logic strobe,
                                    input logic [1:0] addr,
                                    input logic [1:0] code);
    return strobe && (addr == code);
  endfunction

  assign pins[PIN_SCLK]  = serial_clk_i;
  assign pins[PIN_SDATA] = serial_data_i;
  assign pins[PIN_LOAD]  = load_strobe_i;
  assign pins[PIN_OSC]   = osc_i;
  assign pins[PIN_FIN]   = fin_i;

  assign lk.ref_p = q_reg.ref_p;
  assign lk.fb_p  = q_reg.fb_p;
  assign lk.en    = !q_reg.pd;

  lock_filter u_filter (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .lk        (lk.filt)
  );

  always_comb begin
    q_next   = q_reg;
    rise     = q_reg.s2 & ~q_reg.prev;
    frame    = q_reg.sh[SH_W-1:2];
    sh_shift = {q_reg.sh[SH_W-2:0], q_reg.s2[PIN_SDATA]};
    lsel     = q_reg.frac_w[LSEL_MSB:LSEL_LSB];
    fast     = q_reg.pin_w[FAST_BIT];
    test     = q_reg.pin_w[TEST_BIT];
    fmod     = q_reg.frac_w[FRAC_SEL_BIT] ? FMOD_16 : FMOD_15;
    pmod     = q_reg.nw[PRESC_BIT] ? PMOD_HI : PMOD_LO;
    fsum     = 5'(q_reg.acc) + 5'(q_reg.nw[NUM_MSB:0]);
    n_total  = 16'(pmod) * 16'(q_reg.nw[PROG_MSB:PROG_LSB])
             + 16'(q_reg.nw[SWAL_MSB:SWAL_LSB])
             + 16'(q_reg.carry);
    halt     = q_reg.pd || q_reg.nw[CRST_BIT];

    // Pin sampling, first stage feeds only the second
    q_next.s1   = pins;
    q_next.s2   = q_reg.s1;
    q_next.prev = q_reg.s2;

    if (rise[PIN_SCLK]) begin
      q_next.sh = sh_shift;
    end
    // A coincident shift still happens; the load takes the frame as it stood before it
    if (load_hit(rise[PIN_LOAD], q_reg.sh[1:0], ADDR_FRAC)) begin
      q_next.frac_w = frame;
    end
    if (load_hit(rise[PIN_LOAD], q_reg.sh[1:0], ADDR_PIN)) begin
      q_next.pin_w = frame;
    end
    if (load_hit(rise[PIN_LOAD], q_reg.sh[1:0], ADDR_R)) begin
      q_next.rw = frame;
    end
    if (load_hit(rise[PIN_LOAD], q_reg.sh[1:0], ADDR_N)) begin
      q_next.nw = frame;
    end

    // Sleep request: async now, sync waits for the pump to go idle
    if (!q_reg.nw[PWDN_BIT]) begin
      q_next.pd = 1'b0;
    end else if (!q_reg.pin_w[SLEEP_BIT] || !lk.pump_on) begin
      q_next.pd = 1'b1;
    end

    q_next.ref_p = 1'b0;
    q_next.fb_p  = 1'b0;
    if (halt) begin
      q_next.n_cnt = 16'h0000;
      q_next.r_cnt = 15'h0000;
      q_next.acc   = 4'h0;
      q_next.carry = 1'b0;
    end else begin
      if (rise[PIN_FIN]) begin
        if (q_reg.n_cnt + 16'h0001 >= n_total) begin
          q_next.n_cnt = 16'h0000;
          q_next.fb_p  = 1'b1;
          q_next.n_tog = !q_reg.n_tog;
          // Carry stretches the next cycle by one count
          if (fsum >= fmod) begin
            q_next.acc   = 4'(fsum - fmod);
            q_next.carry = 1'b1;
          end else begin
            q_next.acc   = 4'(fsum);
            q_next.carry = 1'b0;
          end
        end else begin
          q_next.n_cnt = q_reg.n_cnt + 16'h0001;
        end
      end
      if (rise[PIN_OSC]) begin
        if (q_reg.r_cnt + 15'h0001 >= q_reg.rw[R_CNT_MSB:0]) begin
          q_next.r_cnt = 15'h0000;
          q_next.ref_p = 1'b1;
          q_next.r_tog = !q_reg.r_tog;
        end else begin
          q_next.r_cnt = q_reg.r_cnt + 15'h0001;
        end
      end
    end

    // Lock pin source
    case (lsel)
      LSEL_ANALOG: begin
        q_next.lk_o  = 1'b0;
        q_next.lk_oe = lk.pump_on;
      end
      LSEL_DIGITAL: begin
        q_next.lk_o  = lk.locked && !lk.pump_on;
        q_next.lk_oe = 1'b1;
      end
      LSEL_NDIV: begin
        q_next.lk_o  = q_reg.n_tog;
        q_next.lk_oe = 1'b1;
      end
      LSEL_RDIV: begin
        q_next.lk_o  = q_reg.r_tog;
        q_next.lk_oe = 1'b1;
      end
      default: begin
        // Disallowed codes: pin released
        q_next.lk_o  = 1'b0;
        q_next.lk_oe = 1'b0;
      end
    endcase

    // General pins: test over fast over general
    if (test) begin
      q_next.a_o  = q_reg.n_tog;
      q_next.a_oe = 1'b1;
      q_next.b_o  = q_reg.r_tog;
      q_next.b_oe = 1'b1;
    end else if (fast) begin
      q_next.a_o  = 1'b0;
      q_next.a_oe = q_reg.rw[CP_TOP_BIT];
      q_next.b_o  = 1'b0;
      q_next.b_oe = 1'b0;
    end else begin
      q_next.a_o  = q_reg.pin_w[OUT_A_BIT];
      q_next.a_oe = 1'b1;
      q_next.b_o  = q_reg.pin_w[OUT_B_BIT];
      q_next.b_oe = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_reg <= ST_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  assign lock_indicator_o       = q_reg.lk_o;
  assign lock_indicator_oe_o    = q_reg.lk_oe;
  assign general_out_a_pin_o    = q_reg.a_o;
  assign general_out_a_pin_oe_o = q_reg.a_oe;
  assign general_out_b_pin_o    = q_reg.b_o;
  assign general_out_b_pin_oe_o = q_reg.b_oe;
  assign powered_down_o         = q_reg.pd;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  property p_shift;
    rise[PIN_SCLK] |=> q_reg.sh == $past(sh_shift);
  endproperty
  a_shift: assert property (p_shift)
    else $error("serial bit not shifted in");

  property p_load_frac;
    rise[PIN_LOAD] && q_reg.sh[1:0] == ADDR_FRAC |=> q_reg.frac_w == $past(frame);
  endproperty
  a_load_frac: assert property (p_load_frac)
    else $error("fraction word not loaded");

  property p_load_pin;
    rise[PIN_LOAD] && q_reg.sh[1:0] == ADDR_PIN |=>
      q_reg.pin_w == $past(frame) && $stable(q_reg.frac_w);
  endproperty
  a_load_pin: assert property (p_load_pin)
    else $error("output word load wrong");

  property p_general;
    !test && !fast |=> general_out_a_pin_oe_o && general_out_b_pin_oe_o &&
      general_out_a_pin_o == $past(q_reg.pin_w[OUT_A_BIT]) &&
      general_out_b_pin_o == $past(q_reg.pin_w[OUT_B_BIT]);
  endproperty
  a_general: assert property (p_general)
    else $error("general pins do not follow bits");

  property p_fast_a;
    !test && fast |=> !general_out_a_pin_o &&
      general_out_a_pin_oe_o == $past(q_reg.rw[CP_TOP_BIT]);
  endproperty
  a_fast_a: assert property (p_fast_a)
    else $error("fast pin A wrong for pump current");

  property p_fast_b;
    !test && fast |=> !general_out_b_pin_oe_o;
  endproperty
  a_fast_b: assert property (p_fast_b)
    else $error("fast pin B driven");

  property p_sleep_now;
    q_reg.nw[PWDN_BIT] && !q_reg.pin_w[SLEEP_BIT] |=> powered_down_o;
  endproperty
  a_sleep_now: assert property (p_sleep_now)
    else $error("immediate sleep late");

  property p_sleep_sync;
    $rose(powered_down_o) && $past(q_reg.pin_w[SLEEP_BIT]) |->
      !$past(lk.pump_on);
  endproperty
  a_sleep_sync: assert property (p_sleep_sync)
    else $error("sleep cut a pump pulse");

  property p_dig_low;
    lsel == LSEL_DIGITAL && !lk.locked |=> !lock_indicator_o;
  endproperty
  a_dig_low: assert property (p_dig_low)
    else $error("digital lock high while unlocked");

  // Disallowed codes must never drive the shared lock pin
  property p_rsv_off;
    lsel != LSEL_ANALOG && lsel != LSEL_DIGITAL && lsel != LSEL_NDIV &&
      lsel != LSEL_RDIV |=> !lock_indicator_oe_o;
  endproperty
  a_rsv_off: assert property (p_rsv_off)
    else $error("reserved lock code drives pin");

  property p_test;
    test |=> general_out_a_pin_oe_o && general_out_b_pin_oe_o;
  endproperty
  a_test: assert property (p_test)
    else $error("test mode pins not driven");

  c_load_n: cover property (rise[PIN_LOAD] && q_reg.sh[1:0] == ADDR_N);
  c_carry: cover property (q_reg.fb_p && q_reg.carry);
  c_dig_lock: cover property (lsel == LSEL_DIGITAL && lock_indicator_o);
endmodule // synth_config

//--- synth_config_lock_outputs_tb.sv
// Purpose: Self-checking bench for the synthesizer configuration block
// Assumes: Divider inputs rise every 8 system cycles
// Notes:   Counts are exact because both divider inputs share one timebase
module synth_config_lock_outputs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import synth_cfg_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       osc = 1'b0;
  logic       fin = 1'b0;
  logic       osc_run = 1'b0;
  logic       fin_run = 1'b0;
  logic [1:0] div4 = 2'h0;
  wire logic  sclk, sdata, strobe, lk, lk_oe, pa, pa_oe, pb, pb_oe, pdn;
  int         errors = 0;
  int         samples_checked = 0;
  int         seed = 32'h635AA427;
  int         cyc;
  logic       ra, rb;
  logic [2:0] rsv [4] = '{3'h1, 3'h3, 3'h4, 3'h5};

  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    div4 <= div4 + 2'h1;
    if (div4 == 2'h3) begin
      if (osc_run) osc <= ~osc;
      if (fin_run) fin <= ~fin;
    end
  end

  host_model u_host (.sys_clk_i(sys_clk), .serial_clk_o(sclk), .serial_data_o(sdata),
                     .load_strobe_o(strobe));
  synth_config u_dut (.sys_clk_i(sys_clk), .rstn_i(rstn), .serial_clk_i(sclk),
    .serial_data_i(sdata), .load_strobe_i(strobe), .osc_i(osc), .fin_i(fin),
    .lock_indicator_o(lk), .lock_indicator_oe_o(lk_oe), .general_out_a_pin_o(pa),
    .general_out_a_pin_oe_o(pa_oe), .general_out_b_pin_o(pb),
    .general_out_b_pin_oe_o(pb_oe), .powered_down_o(pdn));

  // Word builders, unused bits left zero
  function automatic logic [21:0] frac_word(logic m16, logic [2:0] src);
    return (22'(m16) << FRAC_SEL_BIT) | (22'(src) << LSEL_LSB);
  endfunction
  function automatic logic [21:0] pin_word(logic a, logic b, logic t, logic f, logic s);
    return (22'(a) << OUT_A_BIT) | (22'(b) << OUT_B_BIT) | (22'(t) << TEST_BIT)
         | (22'(f) << FAST_BIT) | (22'(s) << SLEEP_BIT);
  endfunction
  function automatic logic [21:0] rw(logic [14:0] r, logic top);
    return 22'(r) | (22'(top) << CP_TOP_BIT);
  endfunction
  function automatic logic [21:0] nw(logic [3:0] num, logic [4:0] a, logic [9:0] b,
                                     logic sl, logic cr);
    return 22'(num) | (22'(a) << SWAL_LSB) | (22'(b) << PROG_LSB)
         | (22'(sl) << PWDN_BIT) | (22'(cr) << CRST_BIT);
  endfunction
  // Expected cycles for a run of divider pulses; inputs rise every 8 cycles
  function automatic int div_cycles(int pulses, int ratio, int extra);
    return (pulses * ratio + extra) * 8;
  endfunction

  task automatic complete_run();
    $display("Checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk_bit(string name, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic chk_cnt(string name, int exp, int got);
    samples_checked++;
    if (got != exp) begin
      errors++;
      $display("Error %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic load(logic [1:0] addr, logic [21:0] data);
    u_host.send(addr, data);
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic wait_tog(inout int k);
    logic last;
    int   n;
    last = lk;
    n = 0;
    while (lk === last && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 2000) begin
      errors++;
      $display("Error lock pin toggle timed out");
      complete_run();
    end
    k += n;
  endtask
  // Cycles taken by n pin toggles, measured from a toggle
  task automatic measure(int n, output int k);
    k = 0;
    wait_tog(k);
    k = 0;
    repeat (n) wait_tog(k);
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk_bit("pin_a_oe", 1'b1, pa_oe);
    chk_bit("pin_a", 1'b0, pa);
    chk_bit("lock_oe_idle", 1'b0, lk_oe);
    repeat (6) begin
      ra = 1'($random(seed));
      rb = 1'($random(seed));
      load(ADDR_PIN, pin_word(ra, rb, 1'b0, 1'b0, 1'b0));
      chk_bit("pin_a", ra, pa);
      chk_bit("pin_b", rb, pb);
      chk_bit("pin_b_oe", 1'b1, pb_oe);
    end
    load(ADDR_R, rw(15'h0031, 1'b1));
    load(ADDR_PIN, pin_word(1'b1, 1'b1, 1'b0, 1'b1, 1'b0));
    chk_bit("fast_a", 1'b0, pa);
    chk_bit("fast_a_oe", 1'b1, pa_oe);
    chk_bit("fast_b_oe", 1'b0, pb_oe);
    load(ADDR_R, rw(15'h0031, 1'b0));
    chk_bit("fast_a_oe", 1'b0, pa_oe);
    load(ADDR_PIN, pin_word(1'b0, 1'b0, 1'b1, 1'b1, 1'b0));
    chk_bit("test_a_oe", 1'b1, pa_oe);
    chk_bit("test_b_oe", 1'b1, pb_oe);
    load(ADDR_PIN, 22'h000000);
    osc_run <= 1'b1;
    fin_run <= 1'b1;
    foreach (rsv[i]) begin
      load(ADDR_FRAC, frac_word(1'b0, rsv[i]));
      chk_bit("lock_oe_rsv", 1'b0, lk_oe);
    end
    // Digital lock: dividers restarted together so their pulses coincide
    load(ADDR_FRAC, frac_word(1'b0, LSEL_DIGITAL));
    load(ADDR_N, nw(4'h0, 5'h01, 10'h003, 1'b0, 1'b1));
    chk_bit("lock_unlocked", 1'b0, lk);
    load(ADDR_N, nw(4'h0, 5'h01, 10'h003, 1'b0, 1'b0));
    repeat (1400) @(posedge sys_clk);
    chk_bit("lock_early", 1'b0, lk);
    repeat (1000) @(posedge sys_clk);
    chk_bit("lock_held", 1'b1, lk);
    fin_run <= 1'b0;
    repeat (800) @(posedge sys_clk);
    chk_bit("lock_lost", 1'b0, lk);
    fin_run <= 1'b1;
    load(ADDR_FRAC, frac_word(1'b0, LSEL_RDIV));
    measure(2, cyc);
    chk_cnt("r_period", div_cycles(2, 49, 0), cyc);
    load(ADDR_FRAC, frac_word(1'b0, LSEL_NDIV));
    measure(2, cyc);
    chk_cnt("n_period", div_cycles(2, 16 * 3 + 1, 0), cyc);
    // Modulus 15 first: accumulator starts at zero, inside both moduli
    load(ADDR_N, nw(4'h3, 5'h01, 10'h003, 1'b0, 1'b0));
    measure(15, cyc);
    chk_cnt("frac15", div_cycles(15, 49, 3), cyc);
    load(ADDR_FRAC, frac_word(1'b1, LSEL_NDIV));
    measure(16, cyc);
    chk_cnt("frac16", div_cycles(16, 49, 3), cyc);
    load(ADDR_N, nw(4'h0, 5'h01, 10'h003, 1'b1, 1'b0));
    chk_bit("sleep", 1'b1, pdn);
    load(ADDR_N, nw(4'h0, 5'h01, 10'h003, 1'b0, 1'b0));
    chk_bit("wake", 1'b0, pdn);
    // Synchronous sleep: may wait up to one divider period for the window
    load(ADDR_PIN, pin_word(1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
    load(ADDR_N, nw(4'h0, 5'h01, 10'h003, 1'b1, 1'b0));
    repeat (400) @(posedge sys_clk);
    chk_bit("sleep_sync", 1'b1, pdn);
    complete_run();
  end
endmodule // synth_config_lock_outputs_tb
